/* File: shared/interval_timer_pkg.sv */
package interval_timer_pkg;

  localparam int unsigned data_width = 32;
  localparam int unsigned addr_width = 8;

  localparam logic [7:0] off_count = 8'h00;
  localparam logic [7:0] off_prescale = 8'h04;
  localparam logic [7:0] off_period = 8'h08;
  localparam logic [7:0] off_irq_status = 8'h0C;
  localparam logic [7:0] off_irq_clear = 8'h10;
  localparam logic [7:0] off_irq_enable = 8'h14;
  localparam logic [7:0] off_control = 8'h18;

  localparam int unsigned ctrl_run_bit = 0;
  localparam int unsigned irq_zero_bit = 0;

  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [7:0] prescale_reset = 8'h00;
  localparam logic [15:0] period_reset = 16'h0000;
  localparam logic [31:0] read_zero = 32'h0000_0000;

  typedef struct packed {
    logic [addr_width-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [data_width-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [data_width-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage : interval_timer_pkg

/* File: core/interval_timer.sv */
// Function
// - Sixteen-bit counter steps down once per elapsed prescale interval.
// - Eight-bit scale holds n minus one; zero decrements every cycle.
// - Counter reaching zero raises the timer interrupt request.
// - On that zero event the counter reloads from the period register.
// - Interrupt request is gated by its enable mask bit.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module interval_timer
  import interval_timer_pkg::*;
#(
  parameter int unsigned count_width = 16,
  parameter int unsigned scale_width = 8
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  output logic timer_irq
);

  // Reset values and the read path are held at the documented widths
  if (count_width < 2 || count_width > 16) begin : g_count_width_check
    $error("count_width must lie between 2 and 16");
  end
  if (scale_width < 1 || scale_width > 8) begin : g_scale_width_check
    $error("scale_width must lie between 1 and 8");
  end

  logic [count_width-1:0] timer_count_value;
  logic [count_width-1:0] timer_reload_period;
  logic [scale_width-1:0] timer_prescale_value;
  logic [scale_width-1:0] prescale_left;
  logic run;
  logic irq_status;
  logic interrupt_enable_mask;
  logic [data_width-1:0] rdata;
  logic slverr;
  logic ready;

  logic [count_width-1:0] next_timer_count_value;
  logic [count_width-1:0] next_timer_reload_period;
  logic [scale_width-1:0] next_timer_prescale_value;
  logic [scale_width-1:0] next_prescale_left;
  logic next_run;
  logic next_irq_status;
  logic next_interrupt_enable_mask;
  logic [data_width-1:0] next_rdata;
  logic next_slverr;
  logic next_ready;
  logic next_timer_irq;

  logic setup;
  // Write strobes, one per writable register
  logic wr_count;
  logic wr_scale;
  logic wr_period;
  logic wr_clear;
  logic wr_enable;
  logic wr_control;
  logic tick;
  logic zero_event;

  function automatic logic mapped(input logic [addr_width-1:0] a);
    mapped = (a == off_count) || (a == off_prescale) || (a == off_period) ||
             (a == off_irq_status) || (a == off_irq_clear) ||
             (a == off_irq_enable) || (a == off_control);
  endfunction : mapped

  // A write lands only in the access cycle, while ready stands
  function automatic logic write_hit(
    input apb_req_t q,
    input logic rdy,
    input logic [addr_width-1:0] off
  );
    write_hit = q.psel && q.penable && q.pwrite && rdy && (q.paddr == off);
  endfunction : write_hit

  // Places a one-bit flag at its field position in a read word
  function automatic logic [data_width-1:0] flag_word(input logic f, input int unsigned pos);
    flag_word = read_zero | (data_width'(f) << pos);
  endfunction : flag_word

  assign setup = apb_req.psel && !apb_req.penable;
  assign wr_count = write_hit(apb_req, ready, off_count);
  assign wr_scale = write_hit(apb_req, ready, off_prescale);
  assign wr_period = write_hit(apb_req, ready, off_period);
  assign wr_clear = write_hit(apb_req, ready, off_irq_clear);
  assign wr_enable = write_hit(apb_req, ready, off_irq_enable);
  assign wr_control = write_hit(apb_req, ready, off_control);
  assign tick = run && (prescale_left == '0);
  // Counter at one about to step means it reaches zero now
  assign zero_event = tick && (timer_count_value == count_width'(1));

  // Register bus: zero-wait slave, answer in the cycle after setup
  always_comb begin
    next_rdata = rdata;
    next_slverr = 1'b0;
    next_ready = setup;
    if (setup) begin
      next_slverr = !mapped(apb_req.paddr);
      case (apb_req.paddr)
        off_count: next_rdata = data_width'(timer_count_value);
        off_prescale: next_rdata = data_width'(timer_prescale_value);
        off_period: next_rdata = data_width'(timer_reload_period);
        off_irq_status: next_rdata = flag_word(irq_status, irq_zero_bit);
        off_irq_enable: next_rdata = flag_word(interrupt_enable_mask, irq_zero_bit);
        off_control: next_rdata = flag_word(run, ctrl_run_bit);
        // Clear register is write-only and reads as zero
        default: next_rdata = read_zero;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= read_zero;
      slverr <= 1'b0;
      ready <= 1'b0;
    end else begin
      rdata <= next_rdata;
      slverr <= next_slverr;
      ready <= next_ready;
    end
  end

  // Settings written by software
  always_comb begin
    next_timer_prescale_value = timer_prescale_value;
    next_timer_reload_period = timer_reload_period;
    next_interrupt_enable_mask = interrupt_enable_mask;
    next_run = run;
    if (wr_scale) begin
      next_timer_prescale_value = apb_req.pwdata[scale_width-1:0];
    end
    if (wr_period) begin
      next_timer_reload_period = apb_req.pwdata[count_width-1:0];
    end
    if (wr_enable) begin
      next_interrupt_enable_mask = apb_req.pwdata[irq_zero_bit];
    end
    if (wr_control) begin
      next_run = apb_req.pwdata[ctrl_run_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_prescale_value <= prescale_reset[scale_width-1:0];
      timer_reload_period <= period_reset[count_width-1:0];
      interrupt_enable_mask <= 1'b0;
      run <= 1'b0;
    end else begin
      timer_prescale_value <= next_timer_prescale_value;
      timer_reload_period <= next_timer_reload_period;
      interrupt_enable_mask <= next_interrupt_enable_mask;
      run <= next_run;
    end
  end

  // Timer: prescaler and down-counter
  always_comb begin
    next_prescale_left = prescale_left;
    next_timer_count_value = timer_count_value;
    if (tick) begin
      next_prescale_left = timer_prescale_value;
    end else if (run) begin
      next_prescale_left = prescale_left - scale_width'(1);
    end
    if (tick) begin
      // A zero already held (written or reset) reloads without an interrupt
      if (zero_event || timer_count_value == '0) begin
        next_timer_count_value = timer_reload_period;
      end else begin
        next_timer_count_value = timer_count_value - count_width'(1);
      end
    end
    // Restarting the interval on a scale or run write keeps the first period whole
    if (wr_scale) begin
      next_prescale_left = apb_req.pwdata[scale_width-1:0];
    end else if (wr_control) begin
      next_prescale_left = timer_prescale_value;
    end
    if (wr_count) begin
      next_timer_count_value = apb_req.pwdata[count_width-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_count_value <= count_reset[count_width-1:0];
      prescale_left <= prescale_reset[scale_width-1:0];
    end else begin
      timer_count_value <= next_timer_count_value;
      prescale_left <= next_prescale_left;
    end
  end

  // Interrupt flag and output
  always_comb begin
    next_irq_status = irq_status;
    if (wr_clear && apb_req.pwdata[irq_zero_bit]) begin
      next_irq_status = 1'b0;
    end
    // Set beats a clear in the same cycle, so no zero event is lost
    if (zero_event) begin
      next_irq_status = 1'b1;
    end
    next_timer_irq = next_irq_status && next_interrupt_enable_mask;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      timer_irq <= next_timer_irq;
    end
  end

  assign apb_rsp.prdata = rdata;
  assign apb_rsp.pready = ready;
  assign apb_rsp.pslverr = slverr;

endmodule : interval_timer

/* File: verification/interval_timer_props.sv */
`timescale 1ns/100ps
module interval_timer_props
  import interval_timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire apb_req_t apb_req,
  input wire apb_rsp_t apb_rsp,
  input wire logic timer_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic en;
  assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) en <= 1'b0;
    else if (wr && apb_req.paddr == off_irq_enable) en <= apb_req.pwdata[irq_zero_bit];
  end
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  setup_ready_a: assert property (setup_s |=> apb_rsp.pready) else $error("no ready");
  ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("long ready");
  err_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready) else $error("lone error");
  err_zero_a: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0) else $error("err data");
  irq_masked_a: assert property (timer_irq |-> en) else $error("masked irq");
  irq_sticky_a: assert property (timer_irq && !wr && !$past(wr) |=> timer_irq)
    else $error("irq dropped");
endmodule : interval_timer_props
bind interval_timer interval_timer_props i_props (.pclk(pclk), .presetn(presetn),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .timer_irq(timer_irq));

/* File: verification/interval_timer_tb_top.sv */
`timescale 1ns/100ps
module interval_timer_tb_top
  import interval_timer_pkg::*;
;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_t;
  row_t rows [5] = '{'{8'h00, 32'hFFFF_ABCD, 32'h0000_ABCD, 1'b0},
    '{8'h04, 32'hFFFF_FF5A, 32'h0000_005A, 1'b0}, '{8'h08, 32'hFFFF_1234, 32'h0000_1234, 1'b0},
    '{8'h10, 32'h0000_0001, 32'h0, 1'b0}, '{8'h1C, 32'h0000_FFFF, 32'h0, 1'b1}};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic timer_irq;
  logic [31:0] r;
  logic e;
  int mismatches = 0;
  int n_checks = 0;
  realtime t1;
  always #25 pclk = ~pclk;
  interval_timer i_interval_timer (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .timer_irq(timer_irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
    req <= '{a, 1'b1, 1'b0, w, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    @(posedge pclk);
  endtask : xf
  task automatic wait_irq;
    do @(posedge pclk); while (timer_irq !== 1'b1);
  endtask : wait_irq
  // Clear first so both rises timed are fresh zero events, not a stale flag
  task automatic measure(input logic [31:0] n);
    xf(off_irq_clear, 1'b1, 32'h1);
    wait_irq();
    t1 = $realtime;
    xf(off_irq_clear, 1'b1, 32'h1);
    wait_irq();
    chk(32'(int'(($realtime - t1) / 50.0)), n);
  endtask : measure
  task automatic print_verdict;
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  initial begin
    #200us;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({30'h0, rsp.pready, timer_irq}, 32'h0);
    foreach (rows[i]) begin
      xf(rows[i].a, 1'b1, rows[i].d);
      xf(rows[i].a, 1'b0, 32'h0);
      chk(r, rows[i].x);
      chk(32'(e), 32'(rows[i].e));
    end
    xf(off_count, 1'b1, 32'h2);
    xf(off_prescale, 1'b1, 32'h2);
    xf(off_period, 1'b1, 32'h3);
    xf(off_irq_enable, 1'b1, 32'h1);
    xf(off_control, 1'b1, 32'h1);
    measure(32'h9);
    xf(off_period, 1'b1, 32'h6);
    xf(off_prescale, 1'b1, 32'h0);
    measure(32'h6);
    xf(off_irq_enable, 1'b1, 32'h0);
    xf(off_irq_clear, 1'b1, 32'h1);
    repeat (12) @(posedge pclk);
    chk(32'(timer_irq), 32'h0);
    xf(off_irq_status, 1'b0, 32'h0);
    chk(r, 32'h1);
    xf(off_irq_enable, 1'b1, 32'h1);
    @(posedge pclk);
    chk(32'(timer_irq), 32'h1);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({30'h0, rsp.pready, timer_irq}, 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    xf(off_count, 1'b0, 32'h0);
    chk(r, 32'(count_reset));
    print_verdict();
  end
endmodule : interval_timer_tb_top
